// >>> rtl/test_pin_pkg.sv
/*
 * shared types and constants for the test and emulation pin mode control.
 * assumes a single 100 MHz system clock samples all test pins.
 */
package test_pin_pkg;

    // ------------------------------------------------------------------
    // pin mode
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_FUNCTIONAL = 2'b00,
        MODE_SCAN       = 2'b01,
        MODE_OFF        = 2'b10
    } pin_mode_t;

    // ------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------
    localparam int        SYNC_STAGES     = 2;
    localparam int        SCAN_LEN_DFLT   = 8;
    localparam logic [1:0] MODE_RESET     = 2'b00;
    localparam logic [3:0] TAP_RESET_STATE = 4'hF;

    // tap scan states kept small: reset, idle and five each on the dr and ir paths (no pause states)
    typedef enum logic [3:0] {
        TAP_RESET    = 4'hF,
        TAP_IDLE     = 4'hC,
        TAP_SEL_DR   = 4'h7,
        TAP_CAP_DR   = 4'h6,
        TAP_SHIFT_DR = 4'h2,
        TAP_EXIT1_DR = 4'h1,
        TAP_UPD_DR   = 4'h5,
        TAP_SEL_IR   = 4'h4,
        TAP_CAP_IR   = 4'hE,
        TAP_SHIFT_IR = 4'hA,
        TAP_EXIT1_IR = 4'h9,
        TAP_UPD_IR   = 4'hD
    } tap_state_t;

    // synchronised view of the external test pins
    typedef struct packed {
        logic test_clk;
        logic test_mode_sel;
        logic test_data_in;
        logic test_rst_n;
        logic event_a_in;
        logic event_b_in;
    } test_pins_t;

    localparam int PIN_COUNT = 6;

    // direction bits written through scan: bit0 pin a drives, bit1 pin b drives
    localparam int DIR_BITS = 2;

endpackage

// >>> rtl/pin_sync.sv
/*
 * two flop synchroniser for a bundle of asynchronous inputs.
 * assumes the inputs are quasi-static with respect to clk.
 */
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // stages
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= meta_d;
            sync_out <= sync_d;
        end
    end

endmodule

// >>> rtl/test_emulation_pin_mode_control.sv
/*
 * test and emulation pin mode control: selects functional, scan or
 * output-disable mode, runs a small tap with a scan direction register,
 * and drives the two emulator event pins and the test data output.
 * assumes all test pins are asynchronous and the test clock is much slower
 * than clk (edges are found by sampling it).
 */
module test_emulation_pin_mode_control #(
    parameter int SCAN_LEN = test_pin_pkg::SCAN_LEN_DFLT
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic test_clk,
    input  wire logic test_mode_sel,
    input  wire logic test_data_in,
    input  wire logic test_rst_n,
    input  wire logic debug_event_pin_a_i,
    input  wire logic debug_event_pin_b_or_output_disable_i,
    input  wire logic event_a_req,
    input  wire logic event_b_req,
    output logic      debug_event_pin_a_o,
    output logic      debug_event_pin_a_oe,
    output logic      debug_event_pin_b_or_output_disable_o,
    output logic      debug_event_pin_b_or_output_disable_oe,
    output logic      test_data_out,
    output logic      test_data_out_oe,
    output logic      event_a_seen,
    output logic      event_b_seen,
    output logic      scan_control,
    output logic      outputs_disabled
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    test_pin_pkg::test_pins_t pins_raw;
    test_pin_pkg::test_pins_t pins;

    always_comb begin
        pins_raw.test_clk      = test_clk;
        pins_raw.test_mode_sel = test_mode_sel;
        pins_raw.test_data_in  = test_data_in;
        pins_raw.test_rst_n    = test_rst_n;
        pins_raw.event_a_in    = debug_event_pin_a_i;
        pins_raw.event_b_in    = debug_event_pin_b_or_output_disable_i;
    end

    pin_sync #(
        .WIDTH (test_pin_pkg::PIN_COUNT)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (pins_raw),
        .sync_out (pins)
    );

    // ------------------------------------------------------------------
    // test clock edges
    // ------------------------------------------------------------------
    logic tck_prev_q;
    logic tck_prev_d;
    logic tck_rise;
    logic tck_fall;

    always_comb begin
        tck_prev_d = pins.test_clk;
        tck_rise   = pins.test_clk & ~tck_prev_q;
        tck_fall   = ~pins.test_clk & tck_prev_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tck_prev_q <= 1'b0;
        end else begin
            tck_prev_q <= tck_prev_d;
        end
    end

    // ------------------------------------------------------------------
    // mode select
    // ------------------------------------------------------------------
    test_pin_pkg::pin_mode_t mode_q;
    test_pin_pkg::pin_mode_t mode_d;

    always_comb begin
        if (pins.test_rst_n) begin
            mode_d = test_pin_pkg::MODE_SCAN;
        end else if (pins.event_a_in && !pins.event_b_in) begin
            mode_d = test_pin_pkg::MODE_OFF;
        end else begin
            mode_d = test_pin_pkg::MODE_FUNCTIONAL;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= test_pin_pkg::MODE_FUNCTIONAL;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ------------------------------------------------------------------
    // tap state machine and scan registers
    // ------------------------------------------------------------------
    test_pin_pkg::tap_state_t tap_q;
    test_pin_pkg::tap_state_t tap_d;
    logic [SCAN_LEN-1:0] ir_q;
    logic [SCAN_LEN-1:0] ir_d;
    logic [SCAN_LEN-1:0] dr_q;
    logic [SCAN_LEN-1:0] dr_d;
    logic [test_pin_pkg::DIR_BITS-1:0] dir_q;
    logic [test_pin_pkg::DIR_BITS-1:0] dir_d;
    logic tdo_q;
    logic tdo_d;
    logic tms;
    logic scanning;

    always_comb begin
        tms   = pins.test_mode_sel;
        tap_d = tap_q;
        ir_d  = ir_q;
        dr_d  = dr_q;
        dir_d = dir_q;
        tdo_d = tdo_q;
        if (!pins.test_rst_n) begin
            tap_d = test_pin_pkg::TAP_RESET;
            dir_d = '0;
        end else if (tck_rise) begin
            unique case (tap_q)
                test_pin_pkg::TAP_RESET:
                    tap_d = tms ? test_pin_pkg::TAP_RESET : test_pin_pkg::TAP_IDLE;
                test_pin_pkg::TAP_IDLE:
                    tap_d = tms ? test_pin_pkg::TAP_SEL_DR : test_pin_pkg::TAP_IDLE;
                test_pin_pkg::TAP_SEL_DR:
                    tap_d = tms ? test_pin_pkg::TAP_SEL_IR : test_pin_pkg::TAP_CAP_DR;
                test_pin_pkg::TAP_CAP_DR: begin
                    dr_d  = {{(SCAN_LEN-test_pin_pkg::DIR_BITS){1'b0}}, dir_q};
                    tap_d = tms ? test_pin_pkg::TAP_EXIT1_DR : test_pin_pkg::TAP_SHIFT_DR;
                end
                test_pin_pkg::TAP_SHIFT_DR: begin
                    dr_d  = {pins.test_data_in, dr_q[SCAN_LEN-1:1]};
                    tap_d = tms ? test_pin_pkg::TAP_EXIT1_DR : test_pin_pkg::TAP_SHIFT_DR;
                end
                test_pin_pkg::TAP_EXIT1_DR:
                    tap_d = tms ? test_pin_pkg::TAP_UPD_DR : test_pin_pkg::TAP_SHIFT_DR;
                test_pin_pkg::TAP_UPD_DR: begin
                    dir_d = dr_q[test_pin_pkg::DIR_BITS-1:0];
                    tap_d = tms ? test_pin_pkg::TAP_SEL_DR : test_pin_pkg::TAP_IDLE;
                end
                test_pin_pkg::TAP_SEL_IR:
                    tap_d = tms ? test_pin_pkg::TAP_RESET : test_pin_pkg::TAP_CAP_IR;
                test_pin_pkg::TAP_CAP_IR: begin
                    ir_d  = {{(SCAN_LEN-1){1'b0}}, 1'b1};
                    tap_d = tms ? test_pin_pkg::TAP_EXIT1_IR : test_pin_pkg::TAP_SHIFT_IR;
                end
                test_pin_pkg::TAP_SHIFT_IR: begin
                    ir_d  = {pins.test_data_in, ir_q[SCAN_LEN-1:1]};
                    tap_d = tms ? test_pin_pkg::TAP_EXIT1_IR : test_pin_pkg::TAP_SHIFT_IR;
                end
                test_pin_pkg::TAP_EXIT1_IR:
                    tap_d = tms ? test_pin_pkg::TAP_UPD_IR : test_pin_pkg::TAP_SHIFT_IR;
                test_pin_pkg::TAP_UPD_IR:
                    tap_d = tms ? test_pin_pkg::TAP_SEL_DR : test_pin_pkg::TAP_IDLE;
                default:
                    tap_d = test_pin_pkg::TAP_RESET;
            endcase
        end else if (tck_fall) begin
            // output bit changes on the falling edge, after the rise shifted it
            if (tap_q == test_pin_pkg::TAP_SHIFT_DR) begin
                tdo_d = dr_q[0];
            end else if (tap_q == test_pin_pkg::TAP_SHIFT_IR) begin
                tdo_d = ir_q[0];
            end
        end
    end

    always_comb begin
        scanning = (tap_q == test_pin_pkg::TAP_SHIFT_DR) ||
                   (tap_q == test_pin_pkg::TAP_SHIFT_IR);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tap_q <= test_pin_pkg::TAP_RESET;
            ir_q  <= '0;
            dr_q  <= '0;
            dir_q <= '0;
            tdo_q <= 1'b0;
        end else begin
            tap_q <= tap_d;
            ir_q  <= ir_d;
            dr_q  <= dr_d;
            dir_q <= dir_d;
            tdo_q <= tdo_d;
        end
    end

    // ------------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------------
    // all outputs registered; disable reaches pins one clk after mode settles
    logic       scan_d;
    logic       off_d;
    logic [5:0] drv_d;
    logic       seen_a_d;
    logic       seen_b_d;

    always_comb begin
        scan_d   = (mode_q == test_pin_pkg::MODE_SCAN);
        off_d    = (mode_q == test_pin_pkg::MODE_OFF);
        // drive order: a_o, a_oe, b_o, b_oe, tdo, tdo_oe
        drv_d[5] = event_a_req;
        drv_d[4] = scan_d && dir_q[0] && !off_d;
        drv_d[3] = event_b_req;
        drv_d[2] = scan_d && dir_q[1] && !off_d;
        drv_d[1] = tdo_q;
        drv_d[0] = scan_d && scanning && !off_d;
        seen_a_d = scan_d && !dir_q[0] && pins.event_a_in;
        seen_b_d = scan_d && !dir_q[1] && pins.event_b_in;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            debug_event_pin_a_o                    <= 1'b0;
            debug_event_pin_a_oe                   <= 1'b0;
            debug_event_pin_b_or_output_disable_o  <= 1'b0;
            debug_event_pin_b_or_output_disable_oe <= 1'b0;
            test_data_out                          <= 1'b0;
            test_data_out_oe                       <= 1'b0;
            event_a_seen                           <= 1'b0;
            event_b_seen                           <= 1'b0;
            scan_control                           <= 1'b0;
            outputs_disabled                       <= 1'b0;
        end else begin
            debug_event_pin_a_o                    <= drv_d[5];
            debug_event_pin_a_oe                   <= drv_d[4];
            debug_event_pin_b_or_output_disable_o  <= drv_d[3];
            debug_event_pin_b_or_output_disable_oe <= drv_d[2];
            test_data_out                          <= drv_d[1];
            test_data_out_oe                       <= drv_d[0];
            event_a_seen                           <= seen_a_d;
            event_b_seen                           <= seen_b_d;
            scan_control                           <= scan_d;
            outputs_disabled                       <= off_d;
        end
    end

endmodule

// >>> testbench/test_pin_props.sv
/* checker for the test pin mode control, on the top module's ports.
   assumes bind onto the top module; one clk domain, rst async high. */
module test_pin_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic test_clk,
    input wire logic test_rst_n,
    input wire logic debug_event_pin_a_i,
    input wire logic debug_event_pin_b_or_output_disable_i,
    input wire logic event_a_req,
    input wire logic event_b_req,
    input wire logic debug_event_pin_a_o,
    input wire logic debug_event_pin_a_oe,
    input wire logic debug_event_pin_b_or_output_disable_o,
    input wire logic debug_event_pin_b_or_output_disable_oe,
    input wire logic test_data_out,
    input wire logic test_data_out_oe,
    input wire logic event_a_seen,
    input wire logic scan_control,
    input wire logic outputs_disabled
);
    timeunit 1ns;
    timeprecision 1ns;

    wire logic pa     = debug_event_pin_a_i;
    wire logic b_o    = debug_event_pin_b_or_output_disable_o;
    wire logic pb     = debug_event_pin_b_or_output_disable_i;
    wire logic a_oe   = debug_event_pin_a_oe;
    wire logic b_oe   = debug_event_pin_b_or_output_disable_oe;
    wire logic any_oe = a_oe || b_oe || test_data_out_oe;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // sequences; six cycles covers the four cycle pin latency plus margin
    // ------------------------------------------------------------------
    sequence off_pins_s;
        !test_rst_n && pa && !pb;
    endsequence
    sequence a_in_high_s;
        scan_control && !a_oe && pa;
    endsequence
    sequence tdo_change_s;
        scan_control && $changed(test_data_out);
    endsequence

    AST_OFF_ENTER: assert property (off_pins_s [*6] |-> outputs_disabled)
        else $error("output disable missing");
    AST_OFF_NEEDS_A: assert property ((!test_rst_n && !pa) [*6] |-> !outputs_disabled)
        else $error("output disable with pin a low");
    AST_OFF_NEEDS_B_LOW: assert property ((!test_rst_n && pb) [*6] |-> !outputs_disabled)
        else $error("output disable with pin b high");
    AST_FUNC: assert property (!test_rst_n [*6] |-> !scan_control && !any_oe)
        else $error("scan activity in functional mode");
    AST_SCAN: assert property (test_rst_n [*6] |-> scan_control && !outputs_disabled)
        else $error("scan control missing");
    AST_OFF_FLOAT: assert property (outputs_disabled |-> !any_oe)
        else $error("driver enabled while disabled");
    AST_TDO_ON_FALL: assert property (tdo_change_s |-> !test_clk && !$past(test_clk, 2))
        else $error("tdo changed outside test clock low phase");
    AST_A_DRIVE: assert property (a_oe |-> debug_event_pin_a_o == $past(event_a_req))
        else $error("pin a drive value wrong");
    AST_B_DRIVE: assert property (b_oe |-> b_o == $past(event_b_req))
        else $error("pin b drive value wrong");
    AST_A_SEEN: assert property (a_in_high_s [*5] |-> event_a_seen)
        else $error("pin a input not seen");
endmodule

bind test_emulation_pin_mode_control test_pin_props i_test_pin_props (
    .clk(clk), .rst(rst), .test_clk(test_clk), .test_rst_n(test_rst_n),
    .debug_event_pin_a_i(debug_event_pin_a_i),
    .debug_event_pin_b_or_output_disable_i(debug_event_pin_b_or_output_disable_i),
    .event_a_req(event_a_req), .event_b_req(event_b_req),
    .debug_event_pin_a_o(debug_event_pin_a_o), .debug_event_pin_a_oe(debug_event_pin_a_oe),
    .debug_event_pin_b_or_output_disable_o(debug_event_pin_b_or_output_disable_o),
    .debug_event_pin_b_or_output_disable_oe(debug_event_pin_b_or_output_disable_oe),
    .test_data_out(test_data_out), .test_data_out_oe(test_data_out_oe),
    .event_a_seen(event_a_seen), .scan_control(scan_control),
    .outputs_disabled(outputs_disabled));

// >>> testbench/jtag_emulator_model.sv
/* emulator side model: drives test clock, mode select and data in.
   assumes clk is the bench clock; one test clock period is 16 clk (160 ns). */
module jtag_emulator_model (
    input  wire logic clk,
    input  wire logic test_data_out,
    input  wire logic test_data_out_oe,
    output logic      test_clk,
    output logic      test_mode_sel,
    output logic      test_data_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // lines start at their pull-up level; the clock stands still between steps
    initial begin
        test_clk = 1'h0;
        test_mode_sel = 1'h1;
        test_data_in = 1'h1;
    end

    // one test clock period; tdo is read just before the rise
    task automatic step(input logic m, input logic d, output logic [1:0] seen);
        test_mode_sel = m;
        test_data_in = d;
        repeat (8) @(negedge clk);
        seen = {test_data_out_oe, test_data_out};
        test_clk = 1'h1;
        repeat (8) @(negedge clk);
        // select and data hold until the next step: an idle restore here
        // would meet that step's assignment in the same time step
        test_clk = 1'h0;
    endtask
endmodule

// >>> testbench/test_emulation_pin_mode_control_bench.sv
/* self-checking bench for the test pin mode control.
   assumes the emulator model and the bound checker are compiled alongside. */
module test_emulation_pin_mode_control_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk, rst, tck, tms, tdi, trst_n, ext_a, ext_b, req_a, req_b;
    logic       a_o, a_oe, b_o, b_oe, tdo, tdo_oe, seen_a, seen_b, scan_c, off;
    logic [1:0] dir_exp;
    logic [7:0] v, got;
    int         err_count;
    int         checked;
    wire logic  pin_a = a_oe ? a_o : ext_a;
    wire logic  pin_b = b_oe ? b_o : ext_b;

    test_emulation_pin_mode_control #(.SCAN_LEN(8)) i_test_emulation_pin_mode_control (
        .clk(clk), .rst(rst), .test_clk(tck), .test_mode_sel(tms), .test_data_in(tdi),
        .test_rst_n(trst_n), .debug_event_pin_a_i(pin_a),
        .debug_event_pin_b_or_output_disable_i(pin_b),
        .event_a_req(req_a), .event_b_req(req_b),
        .debug_event_pin_a_o(a_o), .debug_event_pin_a_oe(a_oe),
        .debug_event_pin_b_or_output_disable_o(b_o),
        .debug_event_pin_b_or_output_disable_oe(b_oe),
        .test_data_out(tdo), .test_data_out_oe(tdo_oe), .event_a_seen(seen_a),
        .event_b_seen(seen_b), .scan_control(scan_c), .outputs_disabled(off));

    jtag_emulator_model i_jtag_emulator_model (
        .clk(clk), .test_data_out(tdo), .test_data_out_oe(tdo_oe),
        .test_clk(tck), .test_mode_sel(tms), .test_data_in(tdi));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] g, input logic [7:0] e, input string what);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask

    task automatic give_verdict();
        if (err_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // pins are slow statics; eight cycles covers the four cycle latency
    task automatic set_pins(input logic t, input logic a, input logic b);
        @(negedge clk);
        trst_n = t;
        ext_a = a;
        ext_b = b;
        repeat (8) @(negedge clk);
    endtask

    // ir high takes the instruction path through select-ir, else a data scan
    task automatic scan_shift(input logic ir, input logic [7:0] d, output logic [7:0] q);
        logic [1:0] s;
        i_jtag_emulator_model.step(1'h0, 1'h1, s);
        i_jtag_emulator_model.step(1'h1, 1'h1, s);
        if (ir) i_jtag_emulator_model.step(1'h1, 1'h1, s);
        i_jtag_emulator_model.step(1'h0, 1'h1, s);
        i_jtag_emulator_model.step(1'h0, 1'h1, s);
        for (int i = 0; i < 8; i++) begin
            i_jtag_emulator_model.step(i == 7, d[i], s);
            q[i] = s[0];
            if (trst_n) check({7'h0, s[1]}, 8'h01, "tdo enable in shift");
        end
        i_jtag_emulator_model.step(1'h1, 1'h1, s);
        i_jtag_emulator_model.step(1'h0, 1'h1, s);
        i_jtag_emulator_model.step(1'h0, 1'h1, s);
    endtask

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    initial begin
        #100000;
        err_count++;
        give_verdict();
    end

    initial begin
        rst = 1'h1;
        trst_n = 1'h0;
        ext_a = 1'h0;
        ext_b = 1'h1;
        req_a = 1'h0;
        req_b = 1'h0;
        err_count = 0;
        checked = 0;
        dir_exp = 2'h0;
        void'($urandom(32'h8BC53F0E));
        repeat (8) @(negedge clk);
        rst = 1'h0;
        // every combination of test reset and both event pins
        for (int i = 0; i < 8; i++) begin
            set_pins(i[2], i[1], i[0]);
            check({7'h0, off}, {7'h0, !i[2] && i[1] && !i[0]}, "disable");
            check({7'h0, scan_c}, {7'h0, i[2]}, "scan control");
            check({5'h0, a_oe, b_oe, tdo_oe}, 8'h00, "enables");
        end
        // a scan while test reset is low must leave directions cleared
        set_pins(1'h0, 1'h0, 1'h1);
        scan_shift(1'h0, 8'hFF, got);
        set_pins(1'h1, 1'h0, 1'h1);
        check({6'h0, a_oe, b_oe}, 8'h00, "ignored scan");
        for (int n = 0; n < 6; n++) begin
            v = (n == 0) ? 8'h03 : (n == 5) ? 8'h02 : 8'($urandom);
            scan_shift(1'h0, v, got);
            check(got, {6'h0, dir_exp}, "captured directions");
            dir_exp = v[1:0];
            check({6'h0, a_oe, b_oe}, {6'h0, dir_exp[0], dir_exp[1]}, "pin enables");
            check({7'h0, tdo_oe}, 8'h00, "tdo float after shift");
            req_a = 1'($urandom);
            req_b = 1'($urandom);
            ext_a = 1'($urandom);
            ext_b = 1'($urandom);
            repeat (8) @(negedge clk);
            check({6'h0, dir_exp[0] ? pin_a : seen_a, dir_exp[1] ? pin_b : seen_b},
                  {6'h0, dir_exp[0] ? req_a : ext_a, dir_exp[1] ? req_b : ext_b},
                  "event pins");
        end
        // instruction scan: capture loads one, directions stay as they are
        scan_shift(1'h1, 8'($urandom), got);
        check(got, 8'h01, "captured instruction");
        check({6'h0, a_oe, b_oe}, {6'h0, dir_exp[0], dir_exp[1]}, "ir scan dirs");
        // off pattern with pin b driven: disable only for board test
        set_pins(1'h0, 1'h1, 1'h0);
        check({4'h0, off, a_oe, b_oe, tdo_oe}, 8'h08, "off from scan");
        set_pins(1'h1, 1'h1, 1'h1);
        repeat (4) @(negedge clk);
        check({6'h0, a_oe, seen_a}, 8'h01, "cleared dirs and pin a seen");
        give_verdict();
    end
endmodule
